// file: pkg/evsel_pkg.sv
package evsel_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int COUNT_W = 48;
	localparam int AMOUNT_W = 4;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CFG_LO = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CFG_HI = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_COUNT_LO = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_COUNT_HI = 8'h0c;

	// field layout of the low control word
	localparam int CODE_LSB = 0;
	localparam int CODE_W = 8;
	localparam int SUB_LSB = 8;
	localparam int SUB_W = 8;
	localparam int EN_BIT = 22;
	// port filter lives at bits [50:36] of the 64-bit control, i.e. [18:4] of the high word
	localparam int PORT_LSB = 4;
	localparam int PORT_W = 15;
	localparam int PART_N = 8;
	localparam int XLAT0_BIT = 8;
	localparam int TOP_LSB = 12;
	localparam logic [2:0] TOP_VALUE = 3'h7;

	localparam logic [CODE_W-1:0] CODE_RST = 8'h00;
	localparam logic [SUB_W-1:0] SUB_RST = 8'h00;
	localparam logic [PORT_W-1:0] PORT_RST = 15'h7fff;

	// event codes
	localparam logic [CODE_W-1:0] EV_NOTHING = 8'h80;
	localparam logic [CODE_W-1:0] EV_SYMBOL_TIMES = 8'h82;
	localparam logic [CODE_W-1:0] EV_PASS_DONE = 8'h90;
	localparam logic [CODE_W-1:0] EV_LINE_DONE = 8'h91;
	localparam logic [CODE_W-1:0] EV_REQ_DONE = 8'h92;
	localparam logic [CODE_W-1:0] EV_OUTBOUND = 8'hc1;

	// subevent bits of the inbound pipeline events
	localparam int SUB_XLAT_ISSUE = 0;
	localparam int SUB_XLAT_RESP = 1;
	localparam int SUB_OWN = 2;
	localparam int SUB_FINAL = 3;
	localparam int SUB_WRITE_LINE = 4;
	localparam int SUB_DATA = 5;
	localparam logic [5:0] POSTED_ONLY = 6'h34;
	localparam logic [5:0] REQ_ONLY = 6'h03;

	// subevent bits of the outbound transaction event
	localparam int SUB_MEM_WR = 0;
	localparam int SUB_PEER_WR = 1;
	localparam int SUB_MEM_RD = 2;
	localparam int SUB_PEER_RD = 3;
	localparam int SUB_CFG_WR = 4;

	// symbol time: link speeds and periods
	localparam int CLK_PERIOD_PS = 10000;
	localparam int SYM_GEN1_PS = 4000;
	localparam int SYM_GEN2_PS = 2000;
	localparam int SYM_GEN3_PS = 1000;
	localparam logic [AMOUNT_W:0] HALF_GEN1 = (AMOUNT_W+1)'(2 * CLK_PERIOD_PS / SYM_GEN1_PS);
	localparam logic [AMOUNT_W:0] HALF_GEN2 = (AMOUNT_W+1)'(2 * CLK_PERIOD_PS / SYM_GEN2_PS);
	localparam logic [AMOUNT_W:0] HALF_GEN3 = (AMOUNT_W+1)'(2 * CLK_PERIOD_PS / SYM_GEN3_PS);
	localparam logic [1:0] SPEED_DOWN = 2'h0;
	localparam logic [1:0] SPEED_GEN1 = 2'h1;
	localparam logic [1:0] SPEED_GEN2 = 2'h2;
	localparam logic [1:0] SPEED_GEN3 = 2'h3;

	typedef enum logic [1:0] {
		TXN_MEM_WR,
		TXN_MEM_RD,
		TXN_CFG_WR,
		TXN_CFG_RD
	} txn_kind_t;

	typedef struct packed {
		logic pass_done;
		logic last_pass;
		logic last_line;
		logic [5:0] stage;
		logic posted;
		logic [2:0] partition;
		logic xlat_type;
	} pipe_event_t;

	typedef struct packed {
		logic issue;
		txn_kind_t kind;
		logic peer;
		logic confined;
		logic [2:0] partition;
		logic xlat_type;
	} txn_event_t;
endpackage : evsel_pkg

// file: src/event_accumulator.sv
`timescale 1ns/1ps
module event_accumulator (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic clear_in,
	input wire logic [evsel_pkg::AMOUNT_W-1:0] amount_in,
	output logic [evsel_pkg::COUNT_W-1:0] count_out
);
	logic [evsel_pkg::COUNT_W-1:0] next_count;

	// a clear in the same cycle as an increment drops that increment
	always_comb begin
		if (clear_in) begin
			next_count = '0;
		end else begin
			next_count = count_out + evsel_pkg::COUNT_W'(amount_in);
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			count_out <= '0;
		end else begin
			count_out <= next_count;
		end
	end
endmodule : event_accumulator

// file: src/io_stack_event_counter_select.sv
// Overview of operation
// - code 0x91 adds one when a cacheline finishes all its pipeline passes.
// - single-pass line: line advance and pass advance occur in the same cycle.
// - single-line request: request advance and line advance occur together.
// - code 0x92 adds one when a whole request finishes all its cachelines.
// - code 0x90 adds one each time a cacheline finishes one pipeline pass.
// - code 0x82 counts symbol times: 4ns gen1, 2ns gen2, 1ns gen3.
// - code 0xc1 counts outbound reads and writes issued toward the cards.
// - memory read and peer read subevents count requests, not completions.
// - peer read and peer write subevents exclude confined peer traffic.
// - every peer read or write is also counted as memory read or write.
// - request-complete subevent bit 0 translation issue, bit 1 translation response.
// - bits 2 own, 3 final, 4 write line, 5 data; 2,4,5 posted only.
// - outbound subevent bit 0 core memory writes, filtered by port field.
// - outbound subevent bit 1 peer writes from another stack, filtered per partition.
// - port filter: bits 0-7 partitions, 8-9 translation types, top three 111.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module io_stack_event_counter_select (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic [evsel_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [evsel_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [evsel_pkg::DATA_W-1:0] reg_rdata_out,
	input wire evsel_pkg::pipe_event_t pipe_in,
	input wire evsel_pkg::txn_event_t txn_in,
	input wire logic [1:0] link_speed_in,
	output logic [evsel_pkg::COUNT_W-1:0] count_out
);
	// port filter decode, shared by inbound and outbound events
	function automatic logic port_match(
		input logic [evsel_pkg::PORT_W-1:0] filter,
		input logic [2:0] partition,
		input logic xlat_type
	);
		logic top_ok;
		logic part_ok;
		logic xlat_ok;
		top_ok = filter[evsel_pkg::TOP_LSB +: 3] == evsel_pkg::TOP_VALUE;
		part_ok = filter[partition];
		xlat_ok = filter[evsel_pkg::XLAT0_BIT + int'(xlat_type)];
		port_match = top_ok && (part_ok || xlat_ok);
	endfunction : port_match

	logic [evsel_pkg::CODE_W-1:0] code;
	logic [evsel_pkg::SUB_W-1:0] sub;
	logic enable;
	logic [evsel_pkg::PORT_W-1:0] port_filter;
	logic [evsel_pkg::CODE_W-1:0] next_code;
	logic [evsel_pkg::SUB_W-1:0] next_sub;
	logic next_enable;
	logic [evsel_pkg::PORT_W-1:0] next_port_filter;
	logic [evsel_pkg::DATA_W-1:0] next_rdata;
	logic count_clear;

	// register bus
	always_comb begin
		next_code = code;
		next_sub = sub;
		next_enable = enable;
		next_port_filter = port_filter;
		count_clear = 1'b0;
		if (reg_wr_in) begin
			case (reg_addr_in)
				evsel_pkg::OFS_CFG_LO: begin
					next_code = reg_wdata_in[evsel_pkg::CODE_LSB +: evsel_pkg::CODE_W];
					next_sub = reg_wdata_in[evsel_pkg::SUB_LSB +: evsel_pkg::SUB_W];
					next_enable = reg_wdata_in[evsel_pkg::EN_BIT];
				end
				evsel_pkg::OFS_CFG_HI: begin
					next_port_filter = reg_wdata_in[evsel_pkg::PORT_LSB +: evsel_pkg::PORT_W];
				end
				evsel_pkg::OFS_COUNT_LO: begin
					count_clear = 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		next_rdata = '0;
		if (reg_rd_in) begin
			case (reg_addr_in)
				evsel_pkg::OFS_CFG_LO: begin
					next_rdata[evsel_pkg::CODE_LSB +: evsel_pkg::CODE_W] = code;
					next_rdata[evsel_pkg::SUB_LSB +: evsel_pkg::SUB_W] = sub;
					next_rdata[evsel_pkg::EN_BIT] = enable;
				end
				evsel_pkg::OFS_CFG_HI: begin
					next_rdata[evsel_pkg::PORT_LSB +: evsel_pkg::PORT_W] = port_filter;
				end
				evsel_pkg::OFS_COUNT_LO: begin
					next_rdata = count_out[evsel_pkg::DATA_W-1:0];
				end
				evsel_pkg::OFS_COUNT_HI: begin
					next_rdata[evsel_pkg::COUNT_W-evsel_pkg::DATA_W-1:0] =
						count_out[evsel_pkg::COUNT_W-1:evsel_pkg::DATA_W];
				end
				default: begin
					next_rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			code <= evsel_pkg::CODE_RST;
			sub <= evsel_pkg::SUB_RST;
			enable <= 1'b0;
			port_filter <= evsel_pkg::PORT_RST;
			reg_rdata_out <= '0;
		end else begin
			code <= next_code;
			sub <= next_sub;
			enable <= next_enable;
			port_filter <= next_port_filter;
			reg_rdata_out <= next_rdata;
		end
	end

	// inbound pipeline: advances derived from one pass strobe so they line up by construction
	logic pass_adv;
	logic line_adv;
	logic req_adv;
	logic [5:0] stage_ok;
	logic pipe_port_ok;
	logic pass_hit;
	logic line_hit;
	logic req_hit;

	assign pass_adv = pipe_in.pass_done;
	assign line_adv = pass_adv && pipe_in.last_pass;
	assign req_adv = line_adv && pipe_in.last_line;

	// stages that only exist for posted requests never match a non-posted one
	always_comb begin
		stage_ok = pipe_in.stage;
		if (!pipe_in.posted) begin
			stage_ok = pipe_in.stage & ~evsel_pkg::POSTED_ONLY;
		end
	end

	assign pipe_port_ok = port_match(port_filter, pipe_in.partition, pipe_in.xlat_type);
	// translation stages are selectable only on the request-complete event
	assign pass_hit = pass_adv && pipe_port_ok
		&& |(stage_ok & sub[5:0] & ~evsel_pkg::REQ_ONLY);
	assign line_hit = line_adv && pipe_port_ok
		&& |(stage_ok & sub[5:0] & ~evsel_pkg::REQ_ONLY);
	assign req_hit = req_adv && pipe_port_ok && |(stage_ok & sub[5:0]);

	// outbound transactions, counted at issue time
	logic [4:0] txn_sub_vec;
	logic txn_hit;
	logic peer_ok;

	assign peer_ok = txn_in.peer && !txn_in.confined;
	always_comb begin
		txn_sub_vec = '0;
		if (txn_in.issue) begin
			txn_sub_vec[evsel_pkg::SUB_MEM_WR] = txn_in.kind == evsel_pkg::TXN_MEM_WR;
			txn_sub_vec[evsel_pkg::SUB_PEER_WR] =
				(txn_in.kind == evsel_pkg::TXN_MEM_WR) && peer_ok;
			txn_sub_vec[evsel_pkg::SUB_MEM_RD] = txn_in.kind == evsel_pkg::TXN_MEM_RD;
			txn_sub_vec[evsel_pkg::SUB_PEER_RD] =
				(txn_in.kind == evsel_pkg::TXN_MEM_RD) && peer_ok;
			txn_sub_vec[evsel_pkg::SUB_CFG_WR] = txn_in.kind == evsel_pkg::TXN_CFG_WR;
		end
	end
	assign txn_hit = |(txn_sub_vec & sub[4:0])
		&& port_match(port_filter, txn_in.partition, txn_in.xlat_type);

	// link speed from the link side: three flops, accepted once the last two agree
	logic [1:0] speed_s1;
	logic [1:0] speed_s2;
	logic [1:0] speed_s3;
	logic [1:0] speed;
	logic [1:0] next_speed;
	logic half_carry;
	logic next_half_carry;
	logic [evsel_pkg::AMOUNT_W:0] half_steps;
	logic [evsel_pkg::AMOUNT_W+1:0] half_total;
	logic [evsel_pkg::AMOUNT_W-1:0] sym_amount;

	always_comb begin
		next_speed = speed;
		if (speed_s2 == speed_s3) begin
			next_speed = speed_s3;
		end
		case (speed)
			evsel_pkg::SPEED_GEN1: half_steps = evsel_pkg::HALF_GEN1;
			evsel_pkg::SPEED_GEN2: half_steps = evsel_pkg::HALF_GEN2;
			evsel_pkg::SPEED_GEN3: half_steps = evsel_pkg::HALF_GEN3;
			default: half_steps = '0;
		endcase
		// gen1 gives 2.5 symbols per clock, so a half symbol is carried over
		half_total = {1'b0, half_steps} + (evsel_pkg::AMOUNT_W+2)'(half_carry);
		sym_amount = half_total[evsel_pkg::AMOUNT_W:1];
		next_half_carry = half_total[0];
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			speed_s1 <= evsel_pkg::SPEED_DOWN;
			speed_s2 <= evsel_pkg::SPEED_DOWN;
			speed_s3 <= evsel_pkg::SPEED_DOWN;
			speed <= evsel_pkg::SPEED_DOWN;
			half_carry <= 1'b0;
		end else begin
			speed_s1 <= link_speed_in;
			speed_s2 <= speed_s1;
			speed_s3 <= speed_s2;
			speed <= next_speed;
			half_carry <= next_half_carry;
		end
	end

	// event select
	logic [evsel_pkg::AMOUNT_W-1:0] amount;
	always_comb begin
		amount = '0;
		if (enable) begin
			case (code)
				evsel_pkg::EV_PASS_DONE: amount = evsel_pkg::AMOUNT_W'(pass_hit);
				evsel_pkg::EV_LINE_DONE: amount = evsel_pkg::AMOUNT_W'(line_hit);
				evsel_pkg::EV_REQ_DONE: amount = evsel_pkg::AMOUNT_W'(req_hit);
				evsel_pkg::EV_OUTBOUND: amount = evsel_pkg::AMOUNT_W'(txn_hit);
				evsel_pkg::EV_SYMBOL_TIMES: amount = sym_amount;
				evsel_pkg::EV_NOTHING: amount = '0;
				default: amount = '0;
			endcase
		end
	end

	event_accumulator u_acc (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.clear_in(count_clear),
		.amount_in(amount),
		.count_out(count_out)
	);

	property p_pass_count;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		(enable && code == evsel_pkg::EV_PASS_DONE && pass_hit && !count_clear)
			|=> count_out == $past(count_out) + 1'b1;
	endproperty
	a_pass_count: assert property (p_pass_count) else $error("pass event not counted");

	property p_line_count;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		(enable && code == evsel_pkg::EV_LINE_DONE && !count_clear)
			|=> count_out == $past(count_out) + $past(line_hit);
	endproperty
	a_line_count: assert property (p_line_count) else $error("line count wrong");

	property p_req_count;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		(enable && code == evsel_pkg::EV_REQ_DONE && !count_clear)
			|=> count_out == $past(count_out) + $past(req_hit);
	endproperty
	a_req_count: assert property (p_req_count) else $error("request count wrong");

	property p_single_pass;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		(pipe_in.pass_done && pipe_in.last_pass) |-> line_adv && pass_adv;
	endproperty
	a_single_pass: assert property (p_single_pass) else $error("line and pass split");

	property p_single_line;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		req_adv |-> line_adv;
	endproperty
	a_single_line: assert property (p_single_line) else $error("request without line");

	property p_gen3_rate;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		(enable && code == evsel_pkg::EV_SYMBOL_TIMES && speed == evsel_pkg::SPEED_GEN3
			&& !count_clear) |=> count_out == $past(count_out) + 48'h00000000000a;
	endproperty
	a_gen3_rate: assert property (p_gen3_rate) else $error("gen3 symbol rate wrong");

	property p_gen1_rate;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		(enable && code == evsel_pkg::EV_SYMBOL_TIMES && speed == evsel_pkg::SPEED_GEN1
			&& !count_clear)[*2] |=> count_out == $past(count_out, 2) + 48'h000000000005;
	endproperty
	a_gen1_rate: assert property (p_gen1_rate) else $error("gen1 symbol rate wrong");

	property p_gen2_rate;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		(enable && code == evsel_pkg::EV_SYMBOL_TIMES && speed == evsel_pkg::SPEED_GEN2
			&& !count_clear) |=> count_out == $past(count_out) + 48'h000000000005;
	endproperty
	a_gen2_rate: assert property (p_gen2_rate) else $error("gen2 symbol rate wrong");

	property p_txn_count;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		(enable && code == evsel_pkg::EV_OUTBOUND && !count_clear)
			|=> count_out == $past(count_out) + $past(txn_hit);
	endproperty
	a_txn_count: assert property (p_txn_count) else $error("outbound count wrong");

	property p_no_confined;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		txn_in.confined
			|-> !txn_sub_vec[evsel_pkg::SUB_PEER_WR] && !txn_sub_vec[evsel_pkg::SUB_PEER_RD];
	endproperty
	a_no_confined: assert property (p_no_confined) else $error("confined peer counted");

	property p_peer_is_mem;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		(txn_sub_vec[evsel_pkg::SUB_PEER_WR] |-> txn_sub_vec[evsel_pkg::SUB_MEM_WR])
		and (txn_sub_vec[evsel_pkg::SUB_PEER_RD] |-> txn_sub_vec[evsel_pkg::SUB_MEM_RD]);
	endproperty
	a_peer_is_mem: assert property (p_peer_is_mem) else $error("peer not also memory");

	property p_posted_only;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		!pipe_in.posted |-> (stage_ok & evsel_pkg::POSTED_ONLY) == 6'h00;
	endproperty
	a_posted_only: assert property (p_posted_only) else $error("posted stage on nonposted");

	property p_one_per_cycle;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		(code != evsel_pkg::EV_SYMBOL_TIMES && !count_clear)
			|=> count_out - $past(count_out) <= 48'h000000000001;
	endproperty
	a_one_per_cycle: assert property (p_one_per_cycle) else $error("more than one per cycle");

	// completions coming back must never look like new outbound requests
	property p_issue_only;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		!txn_in.issue |-> !txn_hit;
	endproperty
	a_issue_only: assert property (p_issue_only) else $error("count without issue");

	property p_filter_top;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		(port_filter[evsel_pkg::TOP_LSB +: 3] != evsel_pkg::TOP_VALUE)
			|-> !pass_hit && !line_hit && !req_hit && !txn_hit;
	endproperty
	a_filter_top: assert property (p_filter_top) else $error("count with filter top unset");
endmodule : io_stack_event_counter_select

// file: tb/io_stack_source.sv
`timescale 1ns/1ps
module io_stack_source (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic go_in,
	input wire evsel_pkg::pipe_event_t pipe_req_in,
	input wire evsel_pkg::txn_event_t txn_req_in,
	output evsel_pkg::pipe_event_t pipe_out,
	output evsel_pkg::txn_event_t txn_out
);
	evsel_pkg::pipe_event_t pipe_idle;
	evsel_pkg::txn_event_t txn_idle;

	// idle fields other than pass_done and issue (held low) flip every cycle so no count can ride on stale qualifiers
	always_comb begin
		pipe_idle = evsel_pkg::pipe_event_t'(~pipe_out);
		pipe_idle.pass_done = 1'b0;
		txn_idle = evsel_pkg::txn_event_t'(~txn_out);
		txn_idle.issue = 1'b0;
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pipe_out <= '0;
			txn_out <= '0;
		end else if (go_in) begin
			pipe_out <= pipe_req_in;
			txn_out <= txn_req_in;
		end else begin
			pipe_out <= pipe_idle;
			txn_out <= txn_idle;
		end
	end
endmodule : io_stack_source

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic clk;
	logic rst_b;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr_s;
	logic rd_s;
	logic [31:0] rdata;
	logic [31:0] rd_val;
	logic go;
	logic [1:0] speed;
	logic [47:0] count;
	logic [47:0] exp_count;
	logic [47:0] c0;
	evsel_pkg::pipe_event_t p_req;
	evsel_pkg::pipe_event_t p_w;
	evsel_pkg::txn_event_t t_req;
	evsel_pkg::txn_event_t t_w;
	logic [7:0] cfg_code;
	logic [7:0] cfg_sub;
	logic [14:0] cfg_port;
	logic cfg_en;
	int fail_count;
	int n_compared;
	logic [7:0] codes [6] = '{evsel_pkg::EV_PASS_DONE, evsel_pkg::EV_LINE_DONE,
		evsel_pkg::EV_REQ_DONE, evsel_pkg::EV_OUTBOUND, evsel_pkg::EV_NOTHING,
		evsel_pkg::EV_OUTBOUND};
	logic [47:0] sym_exp [4] = '{48'h0, 48'h32, 48'h64, 48'hc8};

	io_stack_event_counter_select io_stack_event_counter_select_inst (
		.ref_clk_in(clk), .rst_b_in(rst_b), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .pipe_in(p_w),
		.txn_in(t_w), .link_speed_in(speed), .count_out(count));
	io_stack_source io_stack_source_inst (
		.ref_clk_in(clk), .rst_b_in(rst_b), .go_in(go), .pipe_req_in(p_req),
		.txn_req_in(t_req), .pipe_out(p_w), .txn_out(t_w));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test

	task automatic cmp_word(input string what, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : cmp_word

	task automatic cmp_count(input string what, input logic [47:0] e, input logic [47:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : cmp_count

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		rd_val = rdata;
	endtask : rd

	function automatic logic port_hit(input logic [2:0] part, input logic x);
		return cfg_port[14:12] == 3'h7 && (cfg_port[part] || cfg_port[8 + x]);
	endfunction : port_hit

	function automatic logic [47:0] inc(input evsel_pkg::pipe_event_t p,
		input evsel_pkg::txn_event_t t);
		logic [5:0] m;
		logic ev;
		logic pr;
		logic hit;
		hit = 1'b0;
		m = p.stage & (p.posted ? 6'h3f : 6'h0b);
		if (cfg_code != evsel_pkg::EV_REQ_DONE) begin
			m[1:0] = 2'h0;
		end
		ev = p.pass_done;
		if (cfg_code != evsel_pkg::EV_PASS_DONE) begin
			ev = ev && p.last_pass;
		end
		if (cfg_code == evsel_pkg::EV_REQ_DONE) begin
			ev = ev && p.last_line;
		end
		if (cfg_code inside {evsel_pkg::EV_PASS_DONE, evsel_pkg::EV_LINE_DONE,
			evsel_pkg::EV_REQ_DONE}) begin
			hit = ev && |(m & cfg_sub[5:0]) && port_hit(p.partition, p.xlat_type);
		end
		pr = t.peer && !t.confined;
		m = {1'b0, t.kind == evsel_pkg::TXN_CFG_WR, t.kind == evsel_pkg::TXN_MEM_RD && pr,
			t.kind == evsel_pkg::TXN_MEM_RD, t.kind == evsel_pkg::TXN_MEM_WR && pr,
			t.kind == evsel_pkg::TXN_MEM_WR};
		if (cfg_code == evsel_pkg::EV_OUTBOUND) begin
			hit = t.issue && |(m & cfg_sub[5:0]) && port_hit(t.partition, t.xlat_type);
		end
		return {47'h0, hit && cfg_en};
	endfunction : inc

	task automatic set_cfg(input logic [7:0] c, input logic [7:0] s, input logic [14:0] pf,
		input logic e);
		cfg_code = c;
		cfg_sub = s;
		cfg_port = pf;
		cfg_en = e;
		wr(evsel_pkg::OFS_CFG_LO, {9'h0, e, 6'h0, s, c});
		wr(evsel_pkg::OFS_CFG_HI, {13'h0, pf, 4'h0});
		rd(evsel_pkg::OFS_CFG_LO);
		cmp_word("cfg_lo", {9'h0, e, 6'h0, s, c}, rd_val);
		wr(evsel_pkg::OFS_COUNT_LO, 32'h0);
		exp_count = '0;
	endtask : set_cfg

	task automatic run_events(input int n);
		logic [31:0] r;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			r = $urandom;
			p_req <= r[$bits(p_req)-1:0];
			r = $urandom;
			t_req <= r[$bits(t_req)-1:0];
			go <= (i < n - 2);
			#1;
			cmp_count("count_out", exp_count, count);
			exp_count = exp_count + inc(p_w, t_w);
		end
	endtask : run_events

	initial begin
		#200000;
		fail_count++;
		stop_test();
	end

	initial begin
		void'($urandom(62694));
		rst_b = 1'b0;
		addr = '0;
		wdata = '0;
		wr_s = 1'b0;
		rd_s = 1'b0;
		go = 1'b0;
		p_req = '0;
		t_req = '0;
		speed = evsel_pkg::SPEED_DOWN;
		fail_count = 0;
		n_compared = 0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rd(evsel_pkg::OFS_CFG_LO);
		cmp_word("cfg_lo reset", 32'h0, rd_val);
		rd(evsel_pkg::OFS_CFG_HI);
		cmp_word("cfg_hi reset", 32'h0007fff0, rd_val);
		rd(evsel_pkg::OFS_COUNT_LO);
		cmp_word("count_lo reset", 32'h0, rd_val);
		rd(8'h10);
		cmp_word("unmapped", 32'h0, rd_val);
		// corner cases: disabled code, filter top not 111, then random configs
		for (int i = 0; i < 18; i++) begin
			set_cfg(codes[i % 6], (i < 6) ? 8'h08 : 8'($urandom),
				{(i % 6 == 5) ? 3'h3 : 3'h7, 12'($urandom)}, i != 2);
			run_events(70);
			rd(evsel_pkg::OFS_COUNT_LO);
			cmp_word("count_lo", exp_count[31:0], rd_val);
			rd(evsel_pkg::OFS_COUNT_HI);
			cmp_word("count_hi", {16'h0, exp_count[47:32]}, rd_val);
		end
		// symbol times need the speed to settle through its synchroniser first
		for (int s = 0; s < 4; s++) begin
			@(posedge clk);
			speed <= 2'(s);
			set_cfg(evsel_pkg::EV_SYMBOL_TIMES, 8'h00, 15'h7fff, 1'b1);
			repeat (8) @(posedge clk);
			#1;
			c0 = count;
			repeat (20) @(posedge clk);
			#1;
			cmp_count("symbol_times", sym_exp[s], count - c0);
		end
		stop_test();
	end
endmodule : tb_top
